// file: verilog/psc_pkg.sv
package psc_pkg;
  // configuration offsets, byte addresses within one function's space
  localparam logic [7:0] PSC_OFF_CMD = 8'h04;
  localparam logic [7:0] PSC_OFF_STATUS = 8'h06;
  localparam logic [7:0] PSC_OFF_CLASS = 8'h08;

  // sticky flag vector: index of each flag
  localparam int PSC_NFLAG = 6;
  localparam int PSC_FLG_MASTER_DATA_PARITY_FLAG = 0;
  localparam int PSC_FLG_SIGNALLED_TARGET_ABORT_FLAG = 1;
  localparam int PSC_FLG_RECEIVED_TARGET_ABORT_FLAG = 2;
  localparam int PSC_FLG_MABT = 3;
  localparam int PSC_FLG_SYSERR = 4;
  localparam int PSC_FLG_PARERR = 5;
  localparam logic [5:0] PSC_FLAG_RST = 6'h00;

  // status register field positions
  localparam int PSC_ST_PARERR_BIT = 15;
  localparam int PSC_ST_SIGNALLED_TARGET_ABORT_FLAG_BIT = 11;
  localparam int PSC_ST_DEVSEL_LSB = 9;
  localparam int PSC_ST_MASTER_DATA_PARITY_FLAG_BIT = 8;
  localparam logic [1:0] PSC_DEVSEL_MEDIUM = 2'h1;
  localparam logic [7:0] PSC_ST_LOW_BYTE = 8'h10; // fbb 0, udf 0, 66m 0, cap list 1

  // command register: the two enables kept here
  localparam int PSC_CMD_PERR_EN_BIT = 6;
  localparam int PSC_CMD_SERR_EN_BIT = 8;
  localparam logic PSC_EN_RST = 1'h0;

  // class code and revision
  localparam logic [7:0] PSC_CLASS_BASE = 8'h06;
  localparam logic [7:0] PSC_CLASS_SUB = 8'h07;
  localparam logic [7:0] PSC_CLASS_PROGIF = 8'h00;
  localparam logic [7:0] PSC_REVISION = 8'h3C; // arbitrary value

  localparam int PSC_NFUNC = 2;
  localparam logic [31:0] PSC_RDATA_RST = 32'h0000_0000;

  typedef logic [PSC_NFLAG-1:0] psc_flags_t;
endpackage : psc_pkg

// file: verilog/psc_stat_if.sv
`timescale 1ns/100ps
interface psc_stat_if;
  import psc_pkg::*;
  psc_flags_t set_evt;
  psc_flags_t clr;
  psc_flags_t flags;
  modport bank (input set_evt, input clr, output flags);
  modport ctl (output set_evt, output clr, input flags);
endinterface : psc_stat_if

// file: verilog/psc_flag_bank.sv
`timescale 1ns/100ps
module psc_flag_bank (
  input wire logic clk,
  input wire logic rst_n,
  psc_stat_if.bank st
);
  import psc_pkg::*;

  psc_flags_t flags_q;

  // one sticky flag per bit; the set term is tested first so a
  // clear in the same edge can never swallow an error event
  for (genvar i = 0; i < PSC_NFLAG; i++) begin : g_flag
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        flags_q[i] <= PSC_FLAG_RST[i];
      end else if (st.set_evt[i]) begin
        flags_q[i] <= 1'b1;
      end else if (st.clr[i]) begin
        flags_q[i] <= 1'b0;
      end
    end
  end

  assign st.flags = flags_q;

  AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
    (st.set_evt != '0) |=> ((flags_q & $past(st.set_evt)) == $past(st.set_evt)))
    else $error("set event lost against clear");
endmodule : psc_flag_bank

// file: verilog/psc_cfg_regs.sv
`timescale 1ns/100ps
// Behaviour
// - detected address or data parity sets bit 15
// - enabled system error signalled sets bit 14
// - own master cycle master-aborted sets bit 13
// - own master cycle target-aborted sets bit 12
// - target abort issued as target sets 11
// - writing one clears bits 15-11 and 8
// - bits 10-9 read 01b, medium decode
// - bit 8 needs perr, mastership, response enabled
// - bit 7 reads zero, no fast b2b
// - bit 6 reads zero, no user features
// - bit 5 reads zero, 33 MHz only
// - bit 4 reads one, capability list present
// - bits 3-0 reserved, read zero
// - class reads bridge 06h, subclass 07h, progif 0
// - low class byte holds read-only revision
// - class register at 08h in both functions
// - writing zero leaves a status bit unchanged
// - command bit 6 enables parity response, default off
// - command bit 8 enables system error, default off
module psc_cfg_regs (
  input wire logic clk,
  input wire logic rst_n,
  // configuration access from the bus target engine
  input wire logic cfg_req,
  input wire logic cfg_wr,
  input wire logic cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // error events from the master and target engines
  input wire logic addr_detected_parity_flag,
  input wire logic data_detected_parity_flag,
  input wire logic serr_signalled,
  input wire logic master_abort,
  input wire logic target_abort_rcvd,
  input wire logic target_abort_sent,
  input wire logic perr_seen,
  input wire logic master_this_phase,
  // enables as seen by the bus engines
  output logic perr_resp_en,
  output logic serr_drv_en
);
  import psc_pkg::*;

  psc_stat_if st ();

  logic [PSC_NFUNC-1:0] perr_en_q;
  logic [PSC_NFUNC-1:0] perr_en_d;
  logic [PSC_NFUNC-1:0] serr_en_q;
  logic [PSC_NFUNC-1:0] serr_en_d;
  logic perr_any_q;
  logic serr_any_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [5:0] dw_sel;
  logic wr_cmd;
  logic [15:0] status_word;
  logic [15:0] cmd_word;
  logic [31:0] class_word;
  psc_flags_t set_d;
  psc_flags_t clr_d;

  // dword decode; the status half-word lives in the upper lanes of 04h
  assign dw_sel = cfg_addr[7:2];
  assign wr_cmd = cfg_req && cfg_wr && (dw_sel == PSC_OFF_CMD[7:2]);

  // sticky flag bank, shared by both functions
  psc_flag_bank u_flags (
    .clk (clk),
    .rst_n (rst_n),
    .st (st.bank)
  );

  // hardware set terms; enables are wired OR across the two functions
  always_comb begin
    set_d = '0;
    set_d[PSC_FLG_PARERR] = addr_detected_parity_flag || data_detected_parity_flag;
    set_d[PSC_FLG_SYSERR] = serr_signalled && serr_any_q;
    set_d[PSC_FLG_MABT] = master_abort;
    set_d[PSC_FLG_RECEIVED_TARGET_ABORT_FLAG] = target_abort_rcvd;
    set_d[PSC_FLG_SIGNALLED_TARGET_ABORT_FLAG] = target_abort_sent;
    set_d[PSC_FLG_MASTER_DATA_PARITY_FLAG] = perr_seen && master_this_phase && perr_any_q;
  end

  // write-one-to-clear; all six flags sit in byte lane 3 of dword 04h
  always_comb begin
    clr_d = '0;
    if (wr_cmd && cfg_be[3]) begin
      clr_d[PSC_FLG_PARERR] = cfg_wdata[16 + PSC_ST_PARERR_BIT];
      clr_d[PSC_FLG_SYSERR] = cfg_wdata[16 + PSC_ST_PARERR_BIT - 1];
      clr_d[PSC_FLG_MABT] = cfg_wdata[16 + PSC_ST_PARERR_BIT - 2];
      clr_d[PSC_FLG_RECEIVED_TARGET_ABORT_FLAG] = cfg_wdata[16 + PSC_ST_PARERR_BIT - 3];
      clr_d[PSC_FLG_SIGNALLED_TARGET_ABORT_FLAG] = cfg_wdata[16 + PSC_ST_SIGNALLED_TARGET_ABORT_FLAG_BIT];
      clr_d[PSC_FLG_MASTER_DATA_PARITY_FLAG] = cfg_wdata[16 + PSC_ST_MASTER_DATA_PARITY_FLAG_BIT];
    end
  end

  assign st.set_evt = set_d;
  assign st.clr = clr_d;

  // per-function command enables; lane 0 holds bit 6, lane 1 bit 8
  always_comb begin
    perr_en_d = perr_en_q;
    serr_en_d = serr_en_q;
    if (wr_cmd && cfg_be[0]) begin
      perr_en_d[cfg_func] = cfg_wdata[PSC_CMD_PERR_EN_BIT];
    end
    if (wr_cmd && cfg_be[1]) begin
      serr_en_d[cfg_func] = cfg_wdata[PSC_CMD_SERR_EN_BIT];
    end
  end

  // enables default off after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      perr_en_q <= {PSC_NFUNC{PSC_EN_RST}};
      serr_en_q <= {PSC_NFUNC{PSC_EN_RST}};
    end else begin
      perr_en_q <= perr_en_d;
      serr_en_q <= serr_en_d;
    end
  end

  // registered OR so the engine-facing outputs come from flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      perr_any_q <= PSC_EN_RST;
      serr_any_q <= PSC_EN_RST;
    end else begin
      perr_any_q <= |perr_en_d;
      serr_any_q <= |serr_en_d;
    end
  end

  // read views; every hardwired bit is fixed here, not stored
  always_comb begin
    status_word = {st.flags[PSC_FLG_PARERR], st.flags[PSC_FLG_SYSERR],
                   st.flags[PSC_FLG_MABT], st.flags[PSC_FLG_RECEIVED_TARGET_ABORT_FLAG],
                   st.flags[PSC_FLG_SIGNALLED_TARGET_ABORT_FLAG], PSC_DEVSEL_MEDIUM,
                   st.flags[PSC_FLG_MASTER_DATA_PARITY_FLAG],
                   PSC_ST_LOW_BYTE};
    cmd_word = '0;
    cmd_word[PSC_CMD_PERR_EN_BIT] = perr_en_q[cfg_func];
    cmd_word[PSC_CMD_SERR_EN_BIT] = serr_en_q[cfg_func];
    class_word = {PSC_CLASS_BASE, PSC_CLASS_SUB, PSC_CLASS_PROGIF,
                  PSC_REVISION};
  end

  // read mux; function number is ignored for the class dword
  always_comb begin
    rdata_d = '0;
    if (dw_sel == PSC_OFF_CMD[7:2]) begin
      rdata_d = {status_word, cmd_word};
    end else if (dw_sel == PSC_OFF_CLASS[7:2]) begin
      rdata_d = class_word;
    end
  end

  // every request answers one cycle later; unmapped dwords read zero
  // and writes to them are dropped, so no access can hang the bus
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= PSC_RDATA_RST;
    end else begin
      ack_q <= cfg_req;
      if (cfg_req && !cfg_wr) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign cfg_ack = ack_q;
  assign cfg_rdata = rdata_q;
  assign perr_resp_en = perr_any_q;
  assign serr_drv_en = serr_any_q;

  // ------------------------------------------------------------------
  // checks on the flag bank and the read views

  AST_PARERR_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (addr_detected_parity_flag || data_detected_parity_flag) |=> st.flags[PSC_FLG_PARERR])
    else $error("parity error did not set detected parity flag");

  AST_SYSERR_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (serr_signalled && serr_drv_en) |=> st.flags[PSC_FLG_SYSERR])
    else $error("signalled system error flag not set");

  AST_SYSERR_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(st.flags[PSC_FLG_SYSERR]) |-> $past(serr_signalled && serr_drv_en))
    else $error("system error flag set without enable");

  AST_MABT_SET: assert property (@(posedge clk) disable iff (!rst_n)
    master_abort |=> st.flags[PSC_FLG_MABT])
    else $error("master abort flag not set");

  AST_RECEIVED_TARGET_ABORT_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
    target_abort_rcvd |=> st.flags[PSC_FLG_RECEIVED_TARGET_ABORT_FLAG])
    else $error("received target abort flag not set");

  AST_SIGNALLED_TARGET_ABORT_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
    target_abort_sent |=> st.flags[PSC_FLG_SIGNALLED_TARGET_ABORT_FLAG])
    else $error("signalled target abort flag not set");

  AST_W1C: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_cmd && cfg_be[3] && cfg_wdata[16 + PSC_ST_SIGNALLED_TARGET_ABORT_FLAG_BIT] && !target_abort_sent)
    |=> !st.flags[PSC_FLG_SIGNALLED_TARGET_ABORT_FLAG])
    else $error("write one did not clear target abort flag");

  AST_MASTER_DATA_PARITY_FLAG_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(st.flags[PSC_FLG_MASTER_DATA_PARITY_FLAG])
    |-> $past(perr_seen && master_this_phase && perr_resp_en))
    else $error("data parity flag set without all three conditions");

  AST_ZERO_KEEPS: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_cmd && cfg_be[3] && !cfg_wdata[16 + PSC_ST_PARERR_BIT] && !addr_detected_parity_flag
     && !data_detected_parity_flag) |=> $stable(st.flags[PSC_FLG_PARERR]))
    else $error("writing zero changed detected parity flag");

  AST_STATUS_FIXED: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_req && !cfg_wr && dw_sel == PSC_OFF_CMD[7:2])
    |=> cfg_ack && cfg_rdata[26:16] == {PSC_DEVSEL_MEDIUM, $past(st.flags[PSC_FLG_MASTER_DATA_PARITY_FLAG]),
                                        PSC_ST_LOW_BYTE})
    else $error("hardwired status bits read wrong");

  AST_CLASS_READ: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_req && !cfg_wr && dw_sel == PSC_OFF_CLASS[7:2])
    |=> cfg_rdata == {PSC_CLASS_BASE, PSC_CLASS_SUB, PSC_CLASS_PROGIF, PSC_REVISION})
    else $error("class and revision read wrong");

  AST_CLASS_RO: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_req && cfg_wr && dw_sel == PSC_OFF_CLASS[7:2]) ##2
    (cfg_req && !cfg_wr && dw_sel == PSC_OFF_CLASS[7:2])
    |=> cfg_rdata[7:0] == PSC_REVISION)
    else $error("revision changed by a write");

  AST_EN_DEFAULT: assert property (@(posedge clk) disable iff (!rst_n)
    $past(!rst_n) |-> !perr_resp_en && !serr_drv_en)
    else $error("enables not off after reset");

  AST_PERR_EN_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_cmd && cfg_be[0] && cfg_wdata[PSC_CMD_PERR_EN_BIT]) ##1 !(wr_cmd && cfg_be[0])
    |-> perr_resp_en [*2])
    else $error("parity response enable not taken");

  AST_ACK: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_req |=> cfg_ack)
    else $error("configuration access not answered");

  // answers and read data only move when a request asks for it; a stray
  // acknowledge would let the host pair an answer with the wrong access
  AST_ACK_ONLY_REQ: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_req |=> !cfg_ack)
    else $error("acknowledge without a request");

  AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg_req || cfg_wr) |=> $stable(cfg_rdata))
    else $error("read data moved without a read");

  AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_req && !cfg_wr && dw_sel != PSC_OFF_CMD[7:2] && dw_sel != PSC_OFF_CLASS[7:2])
    |=> cfg_rdata == '0)
    else $error("unmapped dword did not read zero");

  // the command half shows only this function's two enables
  AST_CMD_VIEW: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_req && !cfg_wr && dw_sel == PSC_OFF_CMD[7:2])
    |=> cfg_rdata[15:0] == {7'h00, $past(serr_en_q[cfg_func]), 1'h0,
      $past(perr_en_q[cfg_func]), 6'h00})
    else $error("command half read wrong");

  // the engine-facing enables are the wired OR of both functions
  AST_PERR_OR: assert property (@(posedge clk) disable iff (!rst_n)
    perr_resp_en == |perr_en_q)
    else $error("parity response enable is not the OR of both functions");

  AST_SERR_OR: assert property (@(posedge clk) disable iff (!rst_n)
    serr_drv_en == |serr_en_q)
    else $error("system error enable is not the OR of both functions");

  AST_SERR_EN_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_cmd && cfg_be[1] && cfg_wdata[PSC_CMD_SERR_EN_BIT]) ##1 !(wr_cmd && cfg_be[1])
    |-> serr_drv_en [*2])
    else $error("system error enable not taken");

  // a gated flag stays down while its enable is off
  AST_SYSERR_BLOCKED: assert property (@(posedge clk) disable iff (!rst_n)
    (!serr_drv_en && !st.flags[PSC_FLG_SYSERR]) |=> !st.flags[PSC_FLG_SYSERR])
    else $error("system error flag set while the driver was off");

  AST_MASTER_DATA_PARITY_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (perr_seen && master_this_phase && perr_resp_en) |=> st.flags[PSC_FLG_MASTER_DATA_PARITY_FLAG])
    else $error("data parity flag not set");

  AST_MASTER_DATA_PARITY_FLAG_BLOCKED: assert property (@(posedge clk) disable iff (!rst_n)
    (!perr_resp_en && !st.flags[PSC_FLG_MASTER_DATA_PARITY_FLAG]) |=> !st.flags[PSC_FLG_MASTER_DATA_PARITY_FLAG])
    else $error("data parity flag set while parity response was off");

  // a write to the class dword must touch neither flags nor enables
  AST_CLASS_NO_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_req && cfg_wr && dw_sel == PSC_OFF_CLASS[7:2] && set_d == '0)
    |=> $stable(st.flags) && $stable(perr_resp_en) && $stable(serr_drv_en))
    else $error("class dword write changed other state");

  // per-flag clear rules; the status bit of each flag is worked out here
  // rather than copied from the clear decode, so a lane slip shows up
  for (genvar f = 0; f < PSC_NFLAG; f++) begin : g_flag_chk
    localparam int SBIT = (f == PSC_FLG_MASTER_DATA_PARITY_FLAG) ? PSC_ST_MASTER_DATA_PARITY_FLAG_BIT :
      PSC_ST_SIGNALLED_TARGET_ABORT_FLAG_BIT + f - PSC_FLG_SIGNALLED_TARGET_ABORT_FLAG;

    AST_W1C_EACH: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_cmd && cfg_be[3] && cfg_wdata[16 + SBIT] && !set_d[f]) |=> !st.flags[f])
      else $error("write one did not clear a status flag");

    AST_ZERO_KEEPS_EACH: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_cmd && cfg_be[3] && !cfg_wdata[16 + SBIT] && !set_d[f]) |=> $stable(st.flags[f]))
      else $error("writing zero changed a status flag");

    // an error landing on the clearing write must still be seen afterwards
    AST_SET_EACH: assert property (@(posedge clk) disable iff (!rst_n)
      (set_d[f] && wr_cmd && cfg_be[3] && cfg_wdata[16 + SBIT]) |=> st.flags[f])
      else $error("hardware set lost against a write-one clear");
  end

  // scenarios worth seeing at least once
  COV_W1C_CLEAR: cover property (@(posedge clk) disable iff (!rst_n)
    st.flags[PSC_FLG_PARERR] ##1 !st.flags[PSC_FLG_PARERR]);

  COV_SET_AND_CLEAR: cover property (@(posedge clk) disable iff (!rst_n)
    set_d[PSC_FLG_MABT] && clr_d[PSC_FLG_MABT]);

  COV_MASTER_DATA_PARITY_FLAG: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(st.flags[PSC_FLG_MASTER_DATA_PARITY_FLAG]));

  COV_CLASS_FUNC1: cover property (@(posedge clk) disable iff (!rst_n)
    cfg_req && !cfg_wr && cfg_func && dw_sel == PSC_OFF_CLASS[7:2]);

  COV_SYSERR_SET: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(st.flags[PSC_FLG_SYSERR]));
endmodule : psc_cfg_regs

// file: tb/psc_host_model.sv
`timescale 1ns/100ps
module psc_host_model (
  input wire logic clk,
  output logic cfg_req,
  output logic cfg_wr,
  output logic cfg_func,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata
);
  // idle bus at time zero
  initial begin
    cfg_req = 1'b0;
    cfg_wr = 1'b0;
    cfg_func = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end

  // one access, entered and left just after a falling edge; the answer lands one edge later
  task automatic xfer(input logic wr, input logic fn, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] wd, output logic ack, output logic [31:0] rd);
    cfg_req = 1'b1;
    cfg_wr = wr;
    cfg_func = fn;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = wd;
    @(negedge clk);
    // taken at the rising edge just passed; the answer stands until the next rising edge
    ack = cfg_ack;
    rd = cfg_rdata;
    // released qualifiers are inverted so a stale value can never look valid
    cfg_req = 1'b0;
    cfg_wr = ~wr;
    cfg_func = ~fn;
    cfg_addr = ~a;
    cfg_be = ~be;
    cfg_wdata = ~wd;
    // one idle edge, so a following call never re-raises the request in this time step
    @(negedge clk);
  endtask : xfer
endmodule : psc_host_model

// file: tb/pci_status_and_class_regs_test.sv
`timescale 1ns/100ps
module pci_status_and_class_regs_test;
  import psc_pkg::*;
  localparam logic [31:0] ST0 = 32'h0210_0000;
  localparam logic [31:0] CLS = {8'h06, 8'h07, 8'h00, PSC_REVISION};
  logic clk, rst_n, cfg_req, cfg_wr, cfg_func, cfg_ack, perr_resp_en, serr_drv_en;
  logic [7:0] cfg_addr, ev;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  int failures, num_checks, cycles;
  int bp[6] = '{15, 15, 14, 13, 12, 11};

  psc_host_model host (.clk(clk), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_func(cfg_func),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata));

  psc_cfg_regs uut (.clk(clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
    .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .addr_detected_parity_flag(ev[0]), .data_detected_parity_flag(ev[1]),
    .serr_signalled(ev[2]), .master_abort(ev[3]), .target_abort_rcvd(ev[4]),
    .target_abort_sent(ev[5]), .perr_seen(ev[6]), .master_this_phase(ev[7]),
    .perr_resp_en(perr_resp_en), .serr_drv_en(serr_drv_en));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic rd_chk(input logic fn, input logic [7:0] a, input logic [31:0] exp);
    logic ack;
    logic [31:0] d;
    host.xfer(1'b0, fn, a, 4'h0, 32'h0000_0000, ack, d);
    check({31'h0, ack}, 32'h1);
    check(d, exp);
  endtask : rd_chk

  task automatic wr(input logic fn, input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] wd);
    logic ack;
    logic [31:0] d;
    host.xfer(1'b1, fn, a, be, wd, ack, d);
    check({31'h0, ack}, 32'h1);
  endtask : wr

  // one-cycle event pulse on the selected inputs
  task automatic pulse(input logic [7:0] m);
    ev = m;
    @(negedge clk);
    ev = 8'h00;
    @(negedge clk);
  endtask : pulse

  // hang guard: the sequence needs well under 300 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    rst_n = 1'b0;
    ev = 8'h00;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    check({30'h0, serr_drv_en, perr_resp_en}, 32'h0);
    rd_chk(1'b0, 8'h04, ST0);
    wr(1'b0, 8'h04, 4'hC, 32'h06FF_0000);
    rd_chk(1'b1, 8'h06, ST0);
    $display("test reset_image done");
    rd_chk(1'b0, 8'h08, CLS);
    wr(1'b1, 8'h08, 4'hF, 32'hFFFF_FFFF);
    rd_chk(1'b1, 8'h08, CLS);
    rd_chk(1'b0, 8'h40, 32'h0000_0000);
    $display("test class_code done");
    // each ungated event sets its flag; cleared from the other function than read
    for (int i = 0; i < 6; i++) begin
      if (i != 2) begin
        pulse(8'h01 << i);
        rd_chk(i[0], 8'h04, ST0 | (32'h1 << (16 + bp[i])));
        wr(~i[0], 8'h04, 4'h8, 32'h1 << (16 + bp[i]));
        rd_chk(i[0], 8'h04, ST0);
      end
    end
    $display("test event_flags done");
    pulse(8'h39);
    wr(1'b0, 8'h04, 4'hF, 32'h0000_0000);
    rd_chk(1'b0, 8'h04, 32'hBA10_0000);
    wr(1'b1, 8'h04, 4'h8, 32'h2000_0000);
    rd_chk(1'b0, 8'h04, 32'h9A10_0000);
    wr(1'b0, 8'h04, 4'h8, 32'hF900_0000);
    rd_chk(1'b0, 8'h04, ST0);
    // set and clear of the same flag in one cycle: the set must survive
    fork
      wr(1'b0, 8'h04, 4'h8, 32'h2000_0000);
      begin
        ev = 8'h08;
        @(negedge clk);
        ev = 8'h00;
      end
    join
    rd_chk(1'b0, 8'h04, 32'h2210_0000);
    wr(1'b0, 8'h04, 4'h8, 32'h2000_0000);
    $display("test clear_rules done");
    pulse(8'h04);
    rd_chk(1'b1, 8'h04, ST0);
    wr(1'b1, 8'h04, 4'h2, 32'h0000_0100);
    check({31'h0, serr_drv_en}, 32'h1);
    rd_chk(1'b0, 8'h04, ST0);
    pulse(8'h04);
    rd_chk(1'b1, 8'h04, 32'h4210_0100);
    wr(1'b1, 8'h04, 4'h8, 32'h4000_0000);
    $display("test system_error done");
    pulse(8'hC0);
    rd_chk(1'b0, 8'h04, ST0);
    wr(1'b0, 8'h04, 4'h1, 32'h0000_0040);
    check({31'h0, perr_resp_en}, 32'h1);
    pulse(8'h40);
    pulse(8'h80);
    rd_chk(1'b0, 8'h04, 32'h0210_0040);
    pulse(8'hC0);
    rd_chk(1'b0, 8'h04, 32'h0310_0040);
    wr(1'b1, 8'h04, 4'h8, 32'h0100_0000);
    rd_chk(1'b0, 8'h04, 32'h0210_0040);
    $display("test data_parity done");
    wrap_up();
  end
endmodule : pci_status_and_class_regs_test
